//--- aes_pkg.sv
// Shared constants for the aiming error score memory
package aes_pkg;
  // Clock and times in their own units
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned FIRE_DELAY_MS = 700;
  localparam int unsigned CLR_PULSE_MS = 5;
  localparam int unsigned TICK_HZ = 1;
  // Derived cycle counts
  localparam int unsigned FIRE_DELAY_CYC = (CLK_HZ / 1000) * FIRE_DELAY_MS;
  localparam int unsigned CLR_PULSE_CYC = (CLK_HZ / 1000) * CLR_PULSE_MS;
  localparam int unsigned TICK_CYC = CLK_HZ / TICK_HZ;
  localparam int CNT_W = 27;
  localparam int NUM_RANGES = 10;
  // Direction bit positions inside one range memory
  localparam int DIR_UP = 0;
  localparam int DIR_DOWN = 1;
  localparam int DIR_LEFT = 2;
  localparam int DIR_RIGHT = 3;
  // Register byte offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_ERR_LO = 4'h8;
  localparam logic [3:0] OFS_ERR_HI = 4'hc;
  // Control field positions and reset values
  localparam int CTRL_TGT_LSB = 0;
  localparam int CTRL_SEL_LSB = 4;
  localparam logic [3:0] TGT_RST = 4'ha;
  localparam logic [3:0] SEL_RST = 4'h0;
  localparam logic [3:0] RANGE_MAX = 4'ha;
endpackage

//--- aes_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module aes_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      meta_q <= '0;
      dout <= '0;
    end else if (ce) begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule // aes_sync

//--- aes_range_mem.sv
// One range segment memory with four directional error latches
`timescale 1ns/1ps
module aes_range_mem (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic clr,
  input wire logic en,
  input wire logic [3:0] err,
  output logic [3:0] flags_q
);
  logic [3:0] flags_d;

  // Latch sets only while enabled with an error, holds otherwise; first error wins
  assign flags_d = flags_q | ({4{en}} & err);

  // Reset and memory clear take priority over a set
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      flags_q <= 4'h0;
    end else if (ce) begin
      if (clr) begin
        flags_q <= 4'h0;
      end else begin
        flags_q <= flags_d;
      end
    end
  end
endmodule // aes_range_mem

//--- aes_top.sv
// Aiming error score memory: range counter, range memories, miss logic and readout
//
// Contract
// - Stepping starts 0.7 s after trigger pull and the first decoded output enables range one.
// - Range one's enable also drives range lamp one, the first-range relay and its four error latch gates.
// - A directional latch sets only while its range is enabled and the matching error input is high.
// - A set latch stays set after its enable goes away until a clear.
// - Ranges two to ten follow in order like range one, and only range one passes the clock to the relay.
// - The target range sets the run length and reaching it stops the range counter.
// - In readout the selector routes one range's four latches to the lamps, lit only when set.
// - All error latches clear on the trigger pull clear pulse or the operator clear switch.
// - The miss latch sets when any error input coincides with the active counter clock.
// - A set miss latch lights miss and blocks hit.
// - With no error during the run the hit indication stays selected.
// - At run end the run end relay powers hit and miss and only the selected one lights.
// - The operator clear switch sets a lockout that blocks hit regardless of the miss latch.
// - The fire command sets the run flag which starts the 1 Hz counter clock.
// - Trigger pull or the clear switch makes a memory clear pulse of about 5 ms.
// - Repeated errors in one direction within a range keep only the first.
//
// Our own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
module aes_top
  import aes_pkg::*;
#(
  parameter logic [CNT_W-1:0] P_FIRE_DELAY_CYC = CNT_W'(FIRE_DELAY_CYC),
  parameter logic [CNT_W-1:0] P_TICK_CYC = CNT_W'(TICK_CYC),
  parameter logic [CNT_W-1:0] P_CLR_PULSE_CYC = CNT_W'(CLR_PULSE_CYC)
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic trigger_pull,
  input wire logic operator_clear_switch,
  input wire logic err_up,
  input wire logic err_down,
  input wire logic err_left,
  input wire logic err_right,
  output logic [9:0] range_lamp,
  output logic first_range_relay,
  output logic up_lamp,
  output logic down_lamp,
  output logic left_lamp,
  output logic right_lamp,
  output logic hit_lamp,
  output logic miss_lamp,
  output logic run_end_relay,
  output logic range_stop,
  output logic mem_clear
);
  logic [5:0] pins_s;
  logic [5:0] pins_prev_q;
  logic [3:0] err_s;
  logic trig_rise;
  logic clr_rise;
  logic [3:0] tgt_q;
  logic [3:0] sel_q;
  logic [3:0] tgt_eff;
  logic sel_ok;
  logic [3:0] sel_idx;
  logic [3:0] sel_flags;
  logic [CNT_W-1:0] fire_cnt_q;
  logic fire_armed_q;
  logic fire_done;
  logic [CNT_W-1:0] clr_cnt_q;
  logic [CNT_W-1:0] tick_cnt_q;
  logic tick;
  logic osc_hi;
  logic running_q;
  logic [3:0] range_q;
  logic [9:0] range_en_d;
  logic [9:0] range_en_q;
  logic [39:0] flags_flat;
  logic miss_q;
  logic lockout_q;
  logic run_end_q;
  logic req;
  logic wr_go;
  logic [31:0] rd_mux;

  // Pin inputs through two flip-flops
  aes_sync #(.W(6)) u_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .ce(ce),
    .din({operator_clear_switch, trigger_pull, err_right, err_left, err_down, err_up}),
    .dout(pins_s)
  );

  // Edge detection on synchronised pins
  assign err_s = pins_s[3:0];
  assign trig_rise = pins_s[4] & ~pins_prev_q[4];
  assign clr_rise = pins_s[5] & ~pins_prev_q[5];

  // Timing strobes and range decode
  assign fire_done = fire_armed_q && (fire_cnt_q == P_FIRE_DELAY_CYC - 1'b1);
  assign tick = running_q && (tick_cnt_q == P_TICK_CYC - 1'b1);
  assign osc_hi = running_q && (tick_cnt_q < (P_TICK_CYC >> 1)); // High half of the 1 Hz clock
  assign tgt_eff = ((tgt_q == 4'h0) || (tgt_q > RANGE_MAX)) ? RANGE_MAX : tgt_q;

  // One-hot range enables from the range counter
  always_comb begin
    range_en_d = 10'h000;
    for (int i = 0; i < NUM_RANGES; i++) begin
      range_en_d[i] = running_q && (range_q == 4'(i + 1));
    end
  end

  // Run control: fire delay, 1 Hz clock and range stepping
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      fire_armed_q <= 1'b0;
      fire_cnt_q <= '0;
      running_q <= 1'b0;
      tick_cnt_q <= '0;
      range_q <= 4'h0;
      run_end_q <= 1'b0;
      range_stop <= 1'b0;
    end else if (ce) begin
      range_stop <= 1'b0;
      if (trig_rise) begin
        fire_armed_q <= 1'b1;
        fire_cnt_q <= '0;
        running_q <= 1'b0;
        range_q <= 4'h0;
        run_end_q <= 1'b0;
      end else if (fire_done) begin
        fire_armed_q <= 1'b0;
        running_q <= 1'b1;
        tick_cnt_q <= '0;
        range_q <= 4'h1;
      end else if (fire_armed_q) begin
        fire_cnt_q <= fire_cnt_q + 1'b1;
      end else if (tick) begin
        tick_cnt_q <= '0;
        if (range_q == tgt_eff) begin
          running_q <= 1'b0;
          range_q <= 4'h0;
          run_end_q <= 1'b1;
          range_stop <= 1'b1;
        end else begin
          range_q <= range_q + 4'h1;
        end
      end else if (running_q) begin
        tick_cnt_q <= tick_cnt_q + 1'b1;
      end
    end
  end

  // Memory clear pulse of fixed length on trigger pull or clear switch
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      clr_cnt_q <= '0;
      mem_clear <= 1'b0;
      pins_prev_q <= 6'h00;
    end else if (ce) begin
      pins_prev_q <= pins_s;
      if (trig_rise || clr_rise) begin
        clr_cnt_q <= '0;
        mem_clear <= 1'b1;
      end else if (mem_clear) begin
        clr_cnt_q <= clr_cnt_q + 1'b1;
        if (clr_cnt_q == P_CLR_PULSE_CYC - 1'b1) begin
          mem_clear <= 1'b0;
        end
      end
    end
  end

  // Ten range memories gated by the range enables
  for (genvar g = 0; g < NUM_RANGES; g++) begin : g_mem
    aes_range_mem u_mem (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .ce(ce),
      .clr(mem_clear),
      .en(range_en_q[g]),
      .err(err_s),
      .flags_q(flags_flat[4*g +: 4])
    );
  end

  // Readout routing of the selected range
  assign sel_ok = (sel_q != 4'h0) && (sel_q <= RANGE_MAX);
  assign sel_idx = sel_q - 4'h1;
  assign sel_flags = sel_ok ? flags_flat[4*sel_idx +: 4] : 4'h0;

  // Miss latch, lockout and lamp drivers
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      miss_q <= 1'b0;
      lockout_q <= 1'b0;
      range_en_q <= 10'h000;
      range_lamp <= 10'h000;
      first_range_relay <= 1'b0;
      up_lamp <= 1'b0;
      down_lamp <= 1'b0;
      left_lamp <= 1'b0;
      right_lamp <= 1'b0;
      hit_lamp <= 1'b0;
      miss_lamp <= 1'b0;
      run_end_relay <= 1'b0;
    end else if (ce) begin
      if (trig_rise) begin
        miss_q <= 1'b0;
        lockout_q <= 1'b0;
      end
      // A set in the same cycle as the trigger pull clear wins
      if ((|err_s) && osc_hi) begin
        miss_q <= 1'b1;
      end
      if (clr_rise) begin
        lockout_q <= 1'b1;
      end
      range_en_q <= range_en_d;
      range_lamp <= range_en_d;
      first_range_relay <= range_en_d[0] && osc_hi;
      up_lamp <= !running_q && sel_flags[DIR_UP];
      down_lamp <= !running_q && sel_flags[DIR_DOWN];
      left_lamp <= !running_q && sel_flags[DIR_LEFT];
      right_lamp <= !running_q && sel_flags[DIR_RIGHT];
      run_end_relay <= run_end_q;
      miss_lamp <= run_end_q && miss_q;
      hit_lamp <= run_end_q && !miss_q && !lockout_q;
    end
  end

  // Avalon slave: one wait state, write takes effect when waitrequest is low
  assign req = avs_read || avs_write;
  assign wr_go = avs_write && !avs_waitrequest;

  // Read data selection
  assign rd_mux = (avs_address == OFS_CTRL) ? {24'h000000, sel_q, tgt_q} :
                  (avs_address == OFS_STATUS) ? {22'h000000, mem_clear, lockout_q, run_end_q, miss_q,
                                                 fire_armed_q, running_q, range_q} :
                  (avs_address == OFS_ERR_LO) ? flags_flat[31:0] :
                  (avs_address == OFS_ERR_HI) ? {24'h000000, flags_flat[39:32]} : 32'h00000000;

  // Bus handshake and control register
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      tgt_q <= TGT_RST;
      sel_q <= SEL_RST;
    end else if (ce) begin
      avs_waitrequest <= !(req && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= rd_mux;
      end
      if (wr_go && (avs_address == OFS_CTRL)) begin
        tgt_q <= avs_writedata[CTRL_TGT_LSB +: 4];
        sel_q <= avs_writedata[CTRL_SEL_LSB +: 4];
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_fire_end;
    ce && fire_done && !trig_rise;
  endsequence

  chk_fire_start_range: assert property (s_fire_end |=> running_q && range_q == 4'h1)
    else $error("run did not start at range one after fire delay");
  chk_range_one_en: assert property (ce && range_en_d[0] |=> range_lamp[0] && range_en_q[0])
    else $error("range one enable not driven to lamp and memory");
  chk_latch_cause: assert property ($rose(flags_flat[4 + DIR_LEFT]) |-> $past(range_en_q[1] && err_s[DIR_LEFT]))
    else $error("left latch of range two set without enable and error");
  chk_latch_hold: assert property (flags_flat[4 + DIR_LEFT] && !mem_clear |=> flags_flat[4 + DIR_LEFT])
    else $error("error latch dropped without a clear");
  chk_range_step: assert property (ce && tick && !trig_rise && range_q != tgt_eff
                                   |=> range_q == $past(range_q) + 4'h1)
    else $error("range counter did not advance");
  chk_run_stop: assert property (ce && tick && !trig_rise && range_q == tgt_eff
                                 |=> !running_q && range_stop ##1 !range_stop)
    else $error("run did not stop at the target range");
  chk_lamp_route: assert property (ce && !running_q |=> up_lamp == $past(sel_flags[DIR_UP]))
    else $error("up lamp does not follow selected latch");
  chk_clear_all: assert property (ce && mem_clear |=> flags_flat == 40'h0)
    else $error("latches not cleared by memory clear");
  chk_miss_set: assert property (ce && osc_hi && (|err_s) |=> miss_q)
    else $error("miss latch not set by error during clock");
  chk_hit_miss_excl: assert property (!(hit_lamp && miss_lamp))
    else $error("hit and miss lit together");
  chk_lockout_set: assert property (ce && clr_rise |=> lockout_q ##1 (!$past(ce) || !hit_lamp))
    else $error("lockout not set or hit not blocked");
  chk_clear_pulse: assert property (ce && (trig_rise || clr_rise) |=> mem_clear)
    else $error("memory clear pulse not started");
endmodule // aes_top

//--- aes_far_model.sv
// Far-side model: comparator error lines and panel trigger and clear pins
`timescale 1ns/1ps
module aes_far_model (
  input wire logic clk_sys,
  input wire logic [3:0] err_cmd,
  input wire logic trig_cmd,
  input wire logic clr_cmd,
  output logic err_up,
  output logic err_down,
  output logic err_left,
  output logic err_right,
  output logic trigger_pull,
  output logic operator_clear_switch
);
  // Lines rest low before the first edge
  initial begin
    {err_right, err_left, err_down, err_up} = 4'h0;
    trigger_pull = 1'b0;
    operator_clear_switch = 1'b0;
  end
  // Comparators and switches move just after the edge, as async sources seen by the synchroniser
  always @(posedge clk_sys) begin
    {err_right, err_left, err_down, err_up} <= err_cmd;
    trigger_pull <= trig_cmd;
    operator_clear_switch <= clr_cmd;
  end
endmodule // aes_far_model

//--- aes_top_tb.sv
// Self-checking bench for the aiming error score memory
`timescale 1ns/1ps
module aes_top_tb;
  import aes_pkg::*;
  logic clk_sys, rstn, ce, avs_read, avs_write, avs_waitrequest, trig_cmd, clr_cmd;
  logic trigger_pull, operator_clear_switch, err_up, err_down, err_left, err_right;
  logic first_range_relay, up_lamp, down_lamp, left_lamp, right_lamp, relay_seen, relay_bad;
  logic hit_lamp, miss_lamp, run_end_relay, range_stop, mem_clear;
  logic [3:0] avs_address, err_cmd;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [9:0] range_lamp, last_lamp;
  logic [9:0] seq [$];
  int n_errors, checks_done, i;

  // Short counts keep the run brief
  aes_top #(.P_FIRE_DELAY_CYC(27'd20), .P_TICK_CYC(27'd16), .P_CLR_PULSE_CYC(27'd5)) u_aes_top (
    .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .trigger_pull(trigger_pull),
    .operator_clear_switch(operator_clear_switch), .err_up(err_up), .err_down(err_down),
    .err_left(err_left), .err_right(err_right), .range_lamp(range_lamp),
    .first_range_relay(first_range_relay), .up_lamp(up_lamp), .down_lamp(down_lamp),
    .left_lamp(left_lamp), .right_lamp(right_lamp), .hit_lamp(hit_lamp), .miss_lamp(miss_lamp),
    .run_end_relay(run_end_relay), .range_stop(range_stop), .mem_clear(mem_clear));

  aes_far_model u_aes_far (
    .clk_sys(clk_sys), .err_cmd(err_cmd), .trig_cmd(trig_cmd), .clr_cmd(clr_cmd),
    .err_up(err_up), .err_down(err_down), .err_left(err_left), .err_right(err_right),
    .trigger_pull(trigger_pull), .operator_clear_switch(operator_clear_switch));

  // System clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Logs the range order and watches the relay against range one
  always @(posedge clk_sys) begin
    last_lamp <= range_lamp;
    if (range_lamp !== last_lamp && range_lamp !== 10'h0) seq.push_back(range_lamp);
    if (first_range_relay === 1'b1) relay_seen <= 1'b1;
    if (first_range_relay === 1'b1 && range_lamp[0] !== 1'b1 && last_lamp[0] !== 1'b1) relay_bad <= 1'b1;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One bus cycle, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wait_hi(ref logic s);
    while (s !== 1'b1) @(posedge clk_sys);
  endtask

  task automatic pulse_clear;
    clr_cmd <= 1'b1;
    repeat (4) @(posedge clk_sys);
    clr_cmd <= 1'b0;
    repeat (10) @(posedge clk_sys);
  endtask

  // Sets the target, pulls the trigger, puts errors into range two and waits for the stop
  task automatic fire(input logic [3:0] tgt, input logic [3:0] e);
    bus(1'b1, OFS_CTRL, {28'h0, tgt});
    seq.delete();
    relay_seen <= 1'b0;
    relay_bad <= 1'b0;
    trig_cmd <= 1'b1;
    wait_hi(mem_clear);
    for (i = 0; mem_clear === 1'b1; i++) @(posedge clk_sys);
    check("clear_len", i, 5);
    trig_cmd <= 1'b0;
    if (e !== 4'h0) begin
      while (range_lamp !== 10'h2) @(posedge clk_sys);
      err_cmd <= e;
      repeat (5) @(posedge clk_sys);
      err_cmd <= 4'h0;
    end
    wait_hi(range_stop);
    repeat (3) @(posedge clk_sys);
    check("lamp_off", range_lamp, 10'h0);
    check("relay", {relay_seen, relay_bad}, 2'b10);
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    wrap_up;
  end

  // Main sequence
  initial begin
    {rstn, avs_read, avs_write, trig_cmd, clr_cmd} = 5'h0;
    ce = 1'b1;
    {avs_address, err_cmd, avs_writedata} = 40'h0;
    {n_errors, checks_done, relay_seen, relay_bad, last_lamp} = '0;
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    bus(1'b0, OFS_CTRL, 32'h0);
    check("ctrl_rst", rd, 32'ha);
    bus(1'b1, OFS_STATUS, 32'hffffffff);
    bus(1'b0, OFS_STATUS, 32'h0);
    check("status_rst", rd, 32'h0);
    bus(1'b0, 4'h2, 32'h0);
    check("unmapped", rd, 32'h0);
    err_cmd <= 4'h1;
    repeat (6) @(posedge clk_sys);
    err_cmd <= 4'h0;
    bus(1'b0, OFS_ERR_LO, 32'h0);
    check("idle_err", rd, 32'h0);
    $display("test reset done");
    fire(4'h3, 4'h4);
    check("ranges", {seq[0], seq[1], seq[2]}, {2'b0, 10'h1, 10'h2, 10'h4});
    check("end_miss", {run_end_relay, miss_lamp, hit_lamp}, 3'b110);
    bus(1'b0, OFS_ERR_LO, 32'h0);
    check("err_lo", rd, 32'h40);
    bus(1'b0, OFS_ERR_HI, 32'h0);
    check("err_hi", rd, 32'h0);
    bus(1'b1, OFS_CTRL, 32'h23);
    repeat (2) @(posedge clk_sys);
    check("lamps_r2", {up_lamp, down_lamp, left_lamp, right_lamp}, 4'b0010);
    bus(1'b1, OFS_CTRL, 32'h13);
    repeat (2) @(posedge clk_sys);
    check("lamps_r1", {up_lamp, down_lamp, left_lamp, right_lamp}, 4'b0000);
    pulse_clear;
    bus(1'b0, OFS_ERR_LO, 32'h0);
    check("err_cleared", rd, 32'h0);
    $display("test run one done");
    fire(4'h1, 4'h0);
    check("one_range", seq.size(), 1);
    check("end_hit", {run_end_relay, miss_lamp, hit_lamp}, 3'b101);
    pulse_clear;
    check("lockout", {miss_lamp, hit_lamp}, 2'b00);
    bus(1'b0, OFS_STATUS, 32'h0);
    check("lock_flag", rd & 32'h1c0, 32'h180);
    $display("test run two done");
    // Clock enable low freezes all state, so a trigger pull meanwhile is never seen
    ce <= 1'b0;
    trig_cmd <= 1'b1;
    repeat (8) @(posedge clk_sys);
    trig_cmd <= 1'b0;
    repeat (8) @(posedge clk_sys);
    ce <= 1'b1;
    bus(1'b0, OFS_STATUS, 32'h0);
    check("frozen", rd, 32'h180);
    // Reset later in life clears lockout, run end and lamps and returns control to its reset value
    rstn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    bus(1'b0, OFS_STATUS, 32'h0);
    check("status_rerst", rd, 32'h0);
    check("lamps_rerst", {run_end_relay, miss_lamp, hit_lamp}, 3'b000);
    bus(1'b0, OFS_CTRL, 32'h0);
    check("ctrl_rerst", rd, 32'ha);
    $display("test freeze and reset done");
    wrap_up;
  end
endmodule // aes_top_tb
